// ==== include/pmc_regs.vh ====
/*
  Constants of the power-mode clock controller: register offsets, field
  positions, reset values and clock-source codes.
  Assumes a 32-bit APB register bus, one aligned word per register.
*/
// What this block does
// - The selected power mode is entered only when the low-power instruction executes.
// - Interrupt, reset or watchdog time-out returns any power mode to primary run.
// - From a run mode, Sleep or the matching idle mode may also be entered.
// - Halt bit 7 sets CPU clocking; source field bits 1:0 pick the clock.
// - Halt clear and source 00 at the instruction enter Sleep, CPU and peripheral clocks stopped.
// - Run and idle modes each work from primary, secondary or internal source.
// - Source code 00 primary, 01 secondary timer oscillator, 1x internal block.
// - Primary oscillator mode comes from a configuration register; CPU, peripherals clocked.
// - Primary run clocks CPU and all peripherals from the primary oscillator.
// - Instruction in a run mode with halt set moves to the same-source idle.
// - On idle entry the CPU stops at the next instruction's start.
// - Run-to-idle leaves primary-stable, internal-stable and secondary-running flags unchanged.
// - In idle, peripherals stay clocked from the source selected before entry.
// - Instruction in run mode with halt and source clear enters Sleep as usual.
// - Entering Sleep stops the primary clock and the internal oscillator block.
// - During Sleep the low-frequency RC keeps running while the watchdog is enabled.
// - During Sleep the secondary oscillator runs if its timer-control enable is set.
// - Entering Sleep clears primary-stable, internal-stable and secondary-running flags.
// - Enabled interrupt wakes; branch to vector if global enable set, else resume.
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

`define PMC_DATA_W          32
`define PMC_OFF_OSC_CTRL    8'h00
`define PMC_OFF_TMR_CTRL    8'h04
`define PMC_OFF_CONFIG      8'h08
`define PMC_OFF_STATUS      8'h0c

`define PMC_BIT_HALT        7
`define PMC_BIT_PRI_STABLE  3
`define PMC_BIT_INT_STABLE  2
`define PMC_SRC_HI          1
`define PMC_SRC_LO          0
`define PMC_BIT_SEC_EN      0
`define PMC_BIT_SECONDARY_RUN_MODE     6

`define PMC_SRC_PRI         2'b00
`define PMC_SRC_SEC         2'b01
`define PMC_SRC_INT         2'b10
`define PMC_SRC_INT_BIT     1

`define PMC_CFG_W           3
`define PMC_RST_HALT        1'b0
`define PMC_RST_SRC         2'b00
`define PMC_RST_SEC_EN      1'b0
`define PMC_RST_CFG         3'h0
`define PMC_MODE_W          7
`define PMC_ZERO_WORD       32'h0000_0000

`endif

// ==== hdl/pmc_sync2.v ====
/*
  Two-flop synchroniser for a vector of independent level signals.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module pmc_sync2 #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= din[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign dout = sync_r;

endmodule

// ==== hdl/pmc_power_mode_ctrl.v ====
/*
  Power-mode clock controller: APB register slave, power-mode state
  machine, clock-source stable flags and clock/oscillator enables.
  Assumes sleep_exec, irq_wake, wdt_timeout, global_irq_enable and
  watchdog_enabled come from logic on pclk; oscillator ready levels are
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "pmc_regs.vh"
module pmc_power_mode_ctrl #(
  parameter ADDR_W = 8
) (
  input  wire                     pclk,
  input  wire                     presetn,
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [ADDR_W-1:0]        paddr,
  input  wire [`PMC_DATA_W-1:0]   pwdata,
  output wire [`PMC_DATA_W-1:0]   prdata,
  output wire                     pready,
  output wire                     pslverr,
  input  wire                     sleep_exec,
  input  wire                     irq_wake,
  input  wire                     wdt_timeout,
  input  wire                     global_irq_enable,
  input  wire                     watchdog_enabled,
  input  wire                     primary_osc_ready,
  input  wire                     internal_osc_ready,
  input  wire                     secondary_osc_ready,
  output wire                     cpu_clk_en,
  output wire                     periph_clk_en,
  output wire [1:0]               clk_src_sel,
  output wire                     primary_osc_en,
  output wire                     internal_osc_en,
  output wire                     secondary_osc_en,
  output wire                     low_freq_rc_en,
  output wire [`PMC_CFG_W-1:0]    primary_osc_mode,
  output wire                     wake_to_vector,
  output wire                     wake_resume,
  output wire [`PMC_MODE_W-1:0]   power_mode
);

  localparam [6:0] ST_SLEEP    = 7'h01;
  localparam [6:0] ST_PRIMARY_RUN_MODE  = 7'h02;
  localparam [6:0] ST_SECONDARY_RUN_MODE  = 7'h04;
  localparam [6:0] ST_INT_RUN  = 7'h08;
  localparam [6:0] ST_PRIMARY_IDLE_MODE = 7'h10;
  localparam [6:0] ST_SECONDARY_IDLE_MODE = 7'h20;
  localparam [6:0] ST_INT_IDLE = 7'h40;

  reg                    cpu_halt_select_r;
  reg  [1:0]             clock_source_select_r;
  reg                    sec_timer_en_r;
  reg  [`PMC_CFG_W-1:0]  cfg_r;
  reg  [6:0]             mode_r;
  reg  [6:0]             mode_nxt;
  reg                    primary_osc_stable_flag_r;
  reg                    internal_osc_stable_flag_r;
  reg                    secondary_clock_running_flag_r;
  reg  [`PMC_DATA_W-1:0] prdata_r;
  reg  [`PMC_DATA_W-1:0] rd_word;
  reg                    rd_hit;
  reg                    cpu_clk_en_r;
  reg                    periph_clk_en_r;
  reg  [1:0]             clk_src_sel_r;
  reg  [1:0]             clk_src_nxt;
  reg                    primary_osc_en_r;
  reg                    internal_osc_en_r;
  reg                    secondary_osc_en_r;
  reg                    low_freq_rc_en_r;
  reg                    wake_to_vector_r;
  reg                    wake_resume_r;

  wire [2:0] ready_s;
  wire       pri_ready_s;
  wire       int_ready_s;
  wire       sec_ready_s;

  pmc_sync2 #(
    .W (3)
  ) u_ready_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({secondary_osc_ready, internal_osc_ready, primary_osc_ready}),
    .dout  (ready_s)
  );

  assign pri_ready_s = ready_s[0];
  assign int_ready_s = ready_s[1];
  assign sec_ready_s = ready_s[2];

  // APB decode; the slave never waits
  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_wr     = apb_access & pwrite;
  wire [7:0] addr8 = paddr[7:0];

  always @* begin
    rd_word = `PMC_ZERO_WORD;
    rd_hit  = 1'b1;
    case (addr8)
      `PMC_OFF_OSC_CTRL: begin
        rd_word[`PMC_BIT_HALT]       = cpu_halt_select_r;
        rd_word[`PMC_BIT_PRI_STABLE] = primary_osc_stable_flag_r;
        rd_word[`PMC_BIT_INT_STABLE] = internal_osc_stable_flag_r;
        rd_word[`PMC_SRC_HI:`PMC_SRC_LO] = clock_source_select_r;
      end
      `PMC_OFF_TMR_CTRL: begin
        rd_word[`PMC_BIT_SEC_EN]  = sec_timer_en_r;
        rd_word[`PMC_BIT_SECONDARY_RUN_MODE] = secondary_clock_running_flag_r;
      end
      `PMC_OFF_CONFIG: begin
        rd_word[`PMC_CFG_W-1:0] = cfg_r;
      end
      `PMC_OFF_STATUS: begin
        rd_word[`PMC_MODE_W-1:0] = mode_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~rd_hit;

  // Read data captured in the setup cycle, stable through the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `PMC_ZERO_WORD;
    end else if (apb_setup && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata = prdata_r;

  // Target mode from the control bits at the low-power instruction
  function [6:0] pmc_target;
    input       halt;
    input [1:0] src;
    begin
      if (halt) begin
        if (src[`PMC_SRC_INT_BIT]) begin
          pmc_target = ST_INT_IDLE;
        end else if (src == `PMC_SRC_SEC) begin
          pmc_target = ST_SECONDARY_IDLE_MODE;
        end else begin
          pmc_target = ST_PRIMARY_IDLE_MODE;
        end
      end else begin
        if (src[`PMC_SRC_INT_BIT]) begin
          pmc_target = ST_INT_RUN;
        end else if (src == `PMC_SRC_SEC) begin
          pmc_target = ST_SECONDARY_RUN_MODE;
        end else begin
          pmc_target = ST_SLEEP;
        end
      end
    end
  endfunction

  wire wake    = irq_wake | wdt_timeout;
  wire in_run  = (mode_r == ST_PRIMARY_RUN_MODE) | (mode_r == ST_SECONDARY_RUN_MODE) |
                 (mode_r == ST_INT_RUN);
  wire managed = (mode_r != ST_PRIMARY_RUN_MODE);

  // Wake beats a simultaneous instruction outside primary run; in primary run the wake is ignored and the instruction taken
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_PRIMARY_RUN_MODE, ST_SECONDARY_RUN_MODE, ST_INT_RUN: begin
        if (wake && managed) begin
          mode_nxt = ST_PRIMARY_RUN_MODE;
        end else if (sleep_exec) begin
          mode_nxt = pmc_target(cpu_halt_select_r,
                                clock_source_select_r);
        end
      end
      ST_SLEEP, ST_PRIMARY_IDLE_MODE, ST_SECONDARY_IDLE_MODE, ST_INT_IDLE: begin
        if (wake) begin
          mode_nxt = ST_PRIMARY_RUN_MODE;
        end
      end
      default: begin
        mode_nxt = ST_PRIMARY_RUN_MODE;
      end
    endcase
  end

  wire enter_sleep = (mode_nxt == ST_SLEEP) && (mode_r != ST_SLEEP);
  wire to_primary  = (mode_nxt == ST_PRIMARY_RUN_MODE) && managed;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= ST_PRIMARY_RUN_MODE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Control registers; a wake back to primary forces the source field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt_select_r     <= `PMC_RST_HALT;
      clock_source_select_r <= `PMC_RST_SRC;
      sec_timer_en_r        <= `PMC_RST_SEC_EN;
      cfg_r                 <= `PMC_RST_CFG;
    end else begin
      if (apb_wr && addr8 == `PMC_OFF_OSC_CTRL) begin
        cpu_halt_select_r <= pwdata[`PMC_BIT_HALT];
      end
      if (to_primary) begin
        clock_source_select_r <= `PMC_SRC_PRI;
      end else if (apb_wr && addr8 == `PMC_OFF_OSC_CTRL) begin
        clock_source_select_r <= pwdata[`PMC_SRC_HI:`PMC_SRC_LO];
      end
      if (apb_wr && addr8 == `PMC_OFF_TMR_CTRL) begin
        sec_timer_en_r <= pwdata[`PMC_BIT_SEC_EN];
      end
      if (apb_wr && addr8 == `PMC_OFF_CONFIG) begin
        cfg_r <= pwdata[`PMC_CFG_W-1:0];
      end
    end
  end

  // Clock source that each mode runs the peripherals from
  always @* begin
    case (mode_nxt)
      ST_SECONDARY_RUN_MODE, ST_SECONDARY_IDLE_MODE: clk_src_nxt = `PMC_SRC_SEC;
      ST_INT_RUN, ST_INT_IDLE: clk_src_nxt = `PMC_SRC_INT;
      ST_SLEEP:                clk_src_nxt = clk_src_sel_r;
      default:                 clk_src_nxt = `PMC_SRC_PRI;
    endcase
  end

  wire nxt_sleep = (mode_nxt == ST_SLEEP);
  wire nxt_run   = (mode_nxt == ST_PRIMARY_RUN_MODE) | (mode_nxt == ST_SECONDARY_RUN_MODE) |
                   (mode_nxt == ST_INT_RUN);
  wire nxt_pri   = (mode_nxt == ST_PRIMARY_RUN_MODE) | (mode_nxt == ST_PRIMARY_IDLE_MODE);
  wire nxt_int   = (mode_nxt == ST_INT_RUN) | (mode_nxt == ST_INT_IDLE);
  wire nxt_sec   = (mode_nxt == ST_SECONDARY_RUN_MODE) | (mode_nxt == ST_SECONDARY_IDLE_MODE);

  // Enables follow mode_nxt so they change together with the mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_r       <= 1'b1;
      periph_clk_en_r    <= 1'b1;
      clk_src_sel_r      <= `PMC_SRC_PRI;
      primary_osc_en_r   <= 1'b1;
      internal_osc_en_r  <= 1'b0;
      secondary_osc_en_r <= 1'b0;
      low_freq_rc_en_r   <= 1'b0;
    end else begin
      cpu_clk_en_r       <= nxt_run;
      periph_clk_en_r    <= ~nxt_sleep;
      clk_src_sel_r      <= clk_src_nxt;
      primary_osc_en_r   <= nxt_pri;
      internal_osc_en_r  <= nxt_int;
      secondary_osc_en_r <= nxt_sec | sec_timer_en_r;
      low_freq_rc_en_r   <= watchdog_enabled | nxt_int;
    end
  end

  // Stable flags: cleared only on Sleep entry, held across run-to-idle
  wire pri_set = pri_ready_s & primary_osc_en_r & ~nxt_sleep;
  wire int_set = int_ready_s & internal_osc_en_r & ~nxt_sleep;
  wire sec_set = sec_ready_s & secondary_osc_en_r & ~nxt_sleep;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_osc_stable_flag_r      <= 1'b0;
      internal_osc_stable_flag_r     <= 1'b0;
      secondary_clock_running_flag_r <= 1'b0;
    end else if (enter_sleep) begin
      primary_osc_stable_flag_r      <= 1'b0;
      internal_osc_stable_flag_r     <= 1'b0;
      secondary_clock_running_flag_r <= 1'b0;
    end else begin
      if (pri_set) begin
        primary_osc_stable_flag_r <= 1'b1;
      end
      if (int_set) begin
        internal_osc_stable_flag_r <= 1'b1;
      end
      if (sec_set) begin
        secondary_clock_running_flag_r <= 1'b1;
      end
    end
  end

  // Interrupt wake decides between vector branch and plain resume
  wire irq_exit = irq_wake & to_primary;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_to_vector_r <= 1'b0;
      wake_resume_r    <= 1'b0;
    end else begin
      wake_to_vector_r <= irq_exit & global_irq_enable;
      wake_resume_r    <= irq_exit & ~global_irq_enable;
    end
  end

  assign cpu_clk_en       = cpu_clk_en_r;
  assign periph_clk_en    = periph_clk_en_r;
  assign clk_src_sel      = clk_src_sel_r;
  assign primary_osc_en   = primary_osc_en_r;
  assign internal_osc_en  = internal_osc_en_r;
  assign secondary_osc_en = secondary_osc_en_r;
  assign low_freq_rc_en   = low_freq_rc_en_r;
  assign primary_osc_mode = cfg_r;
  assign wake_to_vector   = wake_to_vector_r;
  assign wake_resume      = wake_resume_r;
  assign power_mode       = mode_r;

endmodule

// ==== tb/pmc_checker.sv ====
/*
  Checker: power-mode and clock-enable relations on the top-level ports.
  Assumes all events are on pclk; bound into pmc_power_mode_ctrl below.
*/
`timescale 1ns/1ps
`include "pmc_regs.vh"
module pmc_checker (
  input wire                   pclk,
  input wire                   presetn,
  input wire                   sleep_exec,
  input wire                   irq_wake,
  input wire                   wdt_timeout,
  input wire                   global_irq_enable,
  input wire                   watchdog_enabled,
  input wire                   cpu_clk_en,
  input wire                   periph_clk_en,
  input wire [1:0]             clk_src_sel,
  input wire                   primary_osc_en,
  input wire                   internal_osc_en,
  input wire                   low_freq_rc_en,
  input wire                   wake_to_vector,
  input wire                   wake_resume,
  input wire [`PMC_MODE_W-1:0] power_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire run  = |power_mode[3:1];
  wire idle = |power_mode[6:4];
  wire wake = irq_wake | wdt_timeout;
  sequence s_wake_req;
    wake && power_mode != 7'h02;
  endsequence
  sequence s_primary_run_mode;
    power_mode == 7'h02 && cpu_clk_en && clk_src_sel == 2'b00;
  endsequence
  AST_WAKE: assert property (s_wake_req |=> s_primary_run_mode)
    else $error("wake did not return to primary run");
  AST_HOLD: assert property (!$stable(power_mode) |-> $past(sleep_exec | wake))
    else $error("power mode changed without an event");
  AST_REFUSE: assert property ((idle || power_mode == 7'h01) && sleep_exec
    && !wake |=> $stable(power_mode))
    else $error("low-power request taken outside a run mode");
  AST_SLEEP: assert property (power_mode == 7'h01 |-> !cpu_clk_en
    && !periph_clk_en && !primary_osc_en && !internal_osc_en)
    else $error("clock left running in sleep");
  AST_IDLE: assert property (idle |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clocking wrong");
  AST_RUN: assert property (run |-> cpu_clk_en && periph_clk_en)
    else $error("run clocking wrong");
  AST_PRI: assert property (power_mode == 7'h02 |-> primary_osc_en)
    else $error("primary oscillator off in primary run");
  AST_LFRC: assert property (power_mode == 7'h01 && watchdog_enabled
    && $past(watchdog_enabled) |-> low_freq_rc_en)
    else $error("rc source stopped with watchdog on");
  AST_VECTOR: assert property (irq_wake && power_mode != 7'h02 |=>
    wake_to_vector == $past(global_irq_enable)
    && wake_resume != $past(global_irq_enable))
    else $error("wake branch choice wrong");
  AST_WDT: assert property (wdt_timeout && !irq_wake
    |=> !wake_to_vector && !wake_resume)
    else $error("watchdog wake gave an interrupt pulse");
  AST_ONEHOT: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
endmodule
bind pmc_power_mode_ctrl pmc_checker u_chk (
  .pclk(pclk), .presetn(presetn), .sleep_exec(sleep_exec),
  .irq_wake(irq_wake), .wdt_timeout(wdt_timeout),
  .global_irq_enable(global_irq_enable),
  .watchdog_enabled(watchdog_enabled), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .clk_src_sel(clk_src_sel),
  .primary_osc_en(primary_osc_en), .internal_osc_en(internal_osc_en),
  .low_freq_rc_en(low_freq_rc_en), .wake_to_vector(wake_to_vector),
  .wake_resume(wake_resume), .power_mode(power_mode)
);

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the power-mode clock controller.
  Assumes zero-wait APB and one-cycle event pulses on pclk.
*/
`timescale 1ns/1ps
`include "pmc_regs.vh"
module testbench;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg         sleep_exec, irq_wake, wdt_timeout, er;
  reg         global_irq_enable, watchdog_enabled;
  wire [31:0] prdata;
  wire        pready, pslverr, cpu_clk_en, periph_clk_en;
  wire [1:0]  clk_src_sel;
  wire        primary_osc_en, internal_osc_en, secondary_osc_en;
  wire        low_freq_rc_en, wake_to_vector, wake_resume;
  wire [2:0]  primary_osc_mode;
  wire [6:0]  power_mode;
  integer     failures, samples_checked, cyc;
  pmc_power_mode_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .irq_wake(irq_wake), .wdt_timeout(wdt_timeout),
    .global_irq_enable(global_irq_enable),
    .watchdog_enabled(watchdog_enabled), .primary_osc_ready(1'b1),
    .internal_osc_ready(1'b1), .secondary_osc_ready(1'b1),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .clk_src_sel(clk_src_sel), .primary_osc_en(primary_osc_en),
    .internal_osc_en(internal_osc_en), .secondary_osc_en(secondary_osc_en),
    .low_freq_rc_en(low_freq_rc_en), .primary_osc_mode(primary_osc_mode),
    .wake_to_vector(wake_to_vector), .wake_resume(wake_resume),
    .power_mode(power_mode));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task print_verdict;
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Drives {sleep_exec, irq_wake, wdt_timeout} for one cycle
  task fire(input [2:0] ev);
    @(posedge pclk);
    {sleep_exec, irq_wake, wdt_timeout} <= ev;
    @(posedge pclk);
    {sleep_exec, irq_wake, wdt_timeout} <= 3'b000;
    #1;
  endtask
  task t_regs;
    apb(0, `PMC_OFF_STATUS, 0); chk(rd, 32'h02);
    chk({cpu_clk_en, periph_clk_en, primary_osc_en}, 3'b111);
    apb(0, `PMC_OFF_OSC_CTRL, 0); chk(rd, 32'h08);
    apb(0, `PMC_OFF_TMR_CTRL, 0); chk(rd, 32'h00);
    apb(0, `PMC_OFF_CONFIG, 0); chk(rd, 32'h00);
    apb(1, `PMC_OFF_CONFIG, 32'h5); apb(0, `PMC_OFF_CONFIG, 0);
    chk(rd, 32'h5);
    chk(primary_osc_mode, 3'h5);
    apb(1, `PMC_OFF_STATUS, 32'h7f); apb(0, `PMC_OFF_STATUS, 0);
    chk(rd, 32'h02);
    apb(0, 8'h10, 0); chk(er, 1); chk(rd, 0);
    chk(pready, 1);
    apb(1, `PMC_OFF_OSC_CTRL, 32'h01); repeat (4) @(posedge pclk);
    chk(power_mode, 7'h02);
  endtask
  task t_modes;
    integer i;
    reg [7:0] c;
    reg [31:0] f;
    for (i = 0; i < 6; i = i + 1) begin
      c = (i < 3) ? 8'h01 + i : 8'h80 + i - 3;
      global_irq_enable <= i[0];
      apb(1, `PMC_OFF_OSC_CTRL, c); apb(0, `PMC_OFF_OSC_CTRL, 0);
      f = rd;
      fire(3'b100);
      chk(power_mode, i == 0 ? 7'h04 : i < 3 ? 7'h08 : 7'h10 << (i - 3));
      chk({cpu_clk_en, periph_clk_en}, {~c[7], 1'b1});
      chk(clk_src_sel, c[1] ? 2'b10 : c[1:0]);
      chk({primary_osc_en, internal_osc_en}, {c[1:0] == 0, c[1]});
      repeat (4) @(posedge pclk);
      if (c[7]) begin
        apb(0, `PMC_OFF_OSC_CTRL, 0); chk(rd[3:2], f[3:2]);
      end
      fire(3'b010);
      chk(power_mode, 7'h02);
      chk({wake_to_vector, wake_resume}, {i[0], ~i[0]});
    end
  endtask
  task t_run_idle;
    apb(1, `PMC_OFF_OSC_CTRL, 32'h01); fire(3'b100);
    chk(power_mode, 7'h04);
    apb(1, `PMC_OFF_OSC_CTRL, 32'h81); fire(3'b100);
    chk(power_mode, 7'h20);
    fire(3'b100); chk(power_mode, 7'h20);
    fire(3'b001); chk(power_mode, 7'h02);
    chk({wake_to_vector, wake_resume}, 2'b00);
  endtask
  task t_sleep;
    watchdog_enabled <= 1'b1;
    global_irq_enable <= 1'b0;
    apb(1, `PMC_OFF_TMR_CTRL, 32'h1);
    apb(1, `PMC_OFF_OSC_CTRL, 32'h02); fire(3'b100);
    chk(power_mode, 7'h08);
    repeat (4) @(posedge pclk);
    apb(0, `PMC_OFF_OSC_CTRL, 0); chk(rd, 32'h0e);
    apb(0, `PMC_OFF_TMR_CTRL, 0); chk(rd, 32'h41);
    apb(1, `PMC_OFF_OSC_CTRL, 32'h00); fire(3'b100);
    chk(power_mode, 7'h01);
    chk({cpu_clk_en, periph_clk_en, primary_osc_en, internal_osc_en}, 0);
    chk({secondary_osc_en, low_freq_rc_en}, 2'b11);
    apb(0, `PMC_OFF_OSC_CTRL, 0); chk(rd, 32'h00);
    apb(0, `PMC_OFF_TMR_CTRL, 0); chk(rd, 32'h01);
    watchdog_enabled <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(low_freq_rc_en, 0);
    fire(3'b010); chk(power_mode, 7'h02);
    chk({wake_to_vector, wake_resume}, 2'b01);
  endtask
  // Run takes about two hundred cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  initial begin
    failures = 0; samples_checked = 0; cyc = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; sleep_exec = 1'b0; irq_wake = 1'b0;
    wdt_timeout = 1'b0; global_irq_enable = 1'b0; watchdog_enabled = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_modes;
    t_run_idle;
    t_sleep;
    print_verdict;
  end
endmodule
